// ### include/rcr_pkg.sv
// Purpose: shared constants and types for the reading comparator and ranging block
// Assumes: 125 MHz system clock, APB register access, 32-bit data
// Notes:   register offsets are byte addresses, one aligned word each
package rcr_pkg;
   // timing
   localparam int CLK_NS   = 8;
   localparam int MS_NS    = 1_000_000;
   localparam int DONE_NS  = 4_250_000;
   localparam int MS_CYC   = MS_NS / CLK_NS;
   localparam int DONE_CYC = DONE_NS / CLK_NS;
   // count limits
   localparam logic [16:0] MAX_COUNT  = 17'h0_59D7;
   localparam logic [16:0] DOWN_TH    = 17'h0_07D0;
   localparam logic [16:0] UP_TH      = 17'h0_4EE8;
   localparam logic [13:0] PCT_MAX    = 14'h270F;
   localparam logic [28:0] PCT_SCALE  = 29'h0000_2710;
   localparam logic [7:0]  DELAY_MIN  = 8'h01;
   localparam logic [7:0]  DELAY_MAX  = 8'hFA;
   localparam logic [4:0]  ADDR_MIN   = 5'h01;
   localparam logic [4:0]  ADDR_MAX   = 5'h1E;
   localparam logic [3:0]  SLOT_COUNT = 4'h9;
   localparam logic [3:0]  RANGE_TOP  = 4'hA;
   localparam logic [3:0]  RANGE_LEAD = 4'h5;
   // register offsets
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_DELAY   = 8'h04;
   localparam logic [7:0] OFS_HI_LIM  = 8'h08;
   localparam logic [7:0] OFS_LO_LIM  = 8'h0C;
   localparam logic [7:0] OFS_HI_PCT  = 8'h10;
   localparam logic [7:0] OFS_LO_PCT  = 8'h14;
   localparam logic [7:0] OFS_NOMINAL = 8'h18;
   localparam logic [7:0] OFS_BUSADDR = 8'h1C;
   localparam logic [7:0] OFS_CMD     = 8'h20;
   localparam logic [7:0] OFS_STATUS  = 8'h24;
   localparam logic [7:0] OFS_READING = 8'h28;
   // field positions
   localparam int CTRL_DISP_LSB = 0;
   localparam int CTRL_TRIG_LSB = 2;
   localparam int CTRL_AUTO_BIT = 4;
   localparam int CTRL_RNG_LSB  = 5;
   localparam int CMD_TRIG_BIT  = 0;
   localparam int CMD_STORE_BIT = 1;
   localparam int CMD_RECALL_BIT = 2;
   localparam int CMD_SLOT_LSB  = 4;
   localparam int ST_OVR_BIT    = 3;
   localparam int ST_LEAD_BIT   = 4;
   localparam int ST_RNG_LSB    = 8;
   localparam int ST_BUSY_BIT   = 12;
   // reset values
   localparam logic [3:0]  RST_RANGE   = 4'hA;
   localparam logic [7:0]  RST_DELAY   = 8'h01;
   localparam logic [14:0] RST_HI_LIM  = 15'h4E20;
   localparam logic [14:0] RST_LO_LIM  = 15'h2710;
   localparam logic [13:0] RST_PCT     = 14'h03E8;
   localparam logic [14:0] RST_NOMINAL = 15'h2710;
   localparam logic [4:0]  RST_ADDR    = 5'h01;

   typedef enum logic [1:0] {DISP_RES, DISP_ABS, DISP_PCT} rcr_disp_t;
   typedef enum logic [1:0] {TRIG_FAST_CONT, TRIG_FAST_ONE, TRIG_DLY_CONT, TRIG_DLY_ONE} rcr_trig_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SETTLE, SEQ_MEAS} rcr_seq_t;

   typedef struct packed {
      rcr_disp_t   disp;
      rcr_trig_t   trig;
      logic        auto_rng;
      logic [3:0]  rng;
      logic [7:0]  delay_ms;
      logic [14:0] hi_lim;
      logic [14:0] lo_lim;
      logic [13:0] hi_pct;
      logic [13:0] lo_pct;
      logic [14:0] nominal;
      logic [4:0]  bus_addr;
   } rcr_setup_t;

   typedef struct packed {
      rcr_setup_t          cfg;
      rcr_setup_t [8:0]    slots;
      rcr_seq_t            seq;
      logic [7:0]          ms_left;
      logic [16:0]         cyc_cnt;
      logic [19:0]         done_cnt;
      logic                done_low;
      logic [16:0]         reading;
      logic                ovr;
      logic [2:0]          cmp;
      logic                start;
      logic                trig_prev;
      logic                trig_pend;
      logic [31:0]         prdata;
   } rcr_state_t;
endpackage

// ### test/rcr_core_model.sv
// Purpose: measurement core stand-in that answers each start with one reading
// Assumes: the reading is ready four cycles after meas_start
// Notes:   the count is scrambled outside the done cycle so no stale value looks valid
`timescale 1ns/100ps
module rcr_core_model (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // block side
   input  wire logic        meas_start,
   output logic             meas_done,
   output logic      [16:0] meas_count,
   // bench control
   input  wire logic [16:0] count_val
);
   logic [2:0] busy_sr;
   always_ff @(posedge clk_sys) begin
      busy_sr    <= rst_n ? {busy_sr[1:0], meas_start} : 3'h0;
      meas_done  <= rst_n & busy_sr[2];
      meas_count <= !rst_n ? 17'h0_0000 : (busy_sr[2] ? count_val : ~meas_count);
   end
endmodule

// ### test/reading_comparator_ranging_tb_top.sv
// Purpose: register and reading sequences for the comparator and ranging block
// Assumes: apb master per transfer; readings triggered from the rear input, the button and the trigger command
// Notes:   short ms and done counts keep the run brief
`timescale 1ns/100ps
module reading_comparator_ranging_tb_top;
   logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, err_v, meas_start, meas_done, lead_check_en, done_n, trig_in_n = 1'b1;
   logic [16:0] meas_count, count_v = 17'h0_2710;
   logic btn = 1'b0;
   localparam int SIM_MS = 10;
   int lat = 0, lat_f = 0;
   logic [3:0] range_sel;
   logic la, lw, lb, ta, tw, tb, ra, rw, rb;
   int n_errors = 0, check_count = 0;
   logic [7:0] ta_a[10] = '{8'h08, 8'h0C, 8'h0C, 8'h04, 8'h04, 8'h04, 8'h1C, 8'h1C, 8'h10,
                            8'h18};
   logic [31:0] ta_d[10] = '{32'h59D8, 32'h4E20, 32'h4E1F, 32'h0, 32'hFB, 32'hFA, 32'h1F,
                             32'h1E, 32'h2710, 32'h59D8};
   logic [31:0] ta_e[10] = '{32'h4E20, 32'h2710, 32'h4E1F, 32'h1, 32'h1, 32'hFA, 32'h1,
                             32'h1E, 32'h3E8, 32'h2710};
   always #4 clk_sys = ~clk_sys;
   rcr_top #(.MS_CYC(SIM_MS), .DONE_CYC(20)) dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .meas_start(meas_start), .meas_done(meas_done),
      .meas_count(meas_count), .range_sel(range_sel), .lead_check_en(lead_check_en),
      .trig_in_n(trig_in_n), .button_trig(btn), .done_n(done_n), .led_above_high(la),
      .led_within(lw), .led_below_low(lb), .ttl_above_high(ta), .ttl_within(tw),
      .ttl_below_low(tb), .relay_above_high(ra), .relay_within(rw), .relay_below_low(rb));
   rcr_core_model core (.clk_sys(clk_sys), .rst_n(rst_n), .meas_start(meas_start),
      .meas_done(meas_done), .meas_count(meas_count), .count_val(count_v));
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1) @(posedge clk_sys);
      rd = prdata; err_v = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic meas(input logic [16:0] c, input logic [2:0] e, input logic [3:0] g);
      count_v <= c;
      trig_in_n <= 1'b0;
      lat = 0;
      do begin
         @(posedge clk_sys);
         lat++;
      end while (done_n !== 1'b0);
      // the trigger stays low for the 10 ms minimum
      repeat (10 * SIM_MS) @(posedge clk_sys);
      trig_in_n <= 1'b1;
      while (done_n !== 1'b1) @(posedge clk_sys);
      chk("leds", 32'(e), 32'({la, lw, lb}));
      chk("ttl relay", 32'({e, e}), 32'({ta, tw, tb, ra, rw, rb}));
      apb(1'b0, rcr_pkg::OFS_STATUS, 32'h0);
      chk("status", 32'({g, 4'h0, c > rcr_pkg::MAX_COUNT, e}), 32'(rd[11:0]));
   endtask
   task automatic mode(input logic [31:0] v);
      apb(1'b1, rcr_pkg::OFS_CTRL, v);
      repeat (40) @(posedge clk_sys);
   endtask
   initial begin
      #200000;
      n_errors++;
      stop_test();
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      apb(1'b0, rcr_pkg::OFS_CTRL, 32'h0);
      chk("ctrl reset", 32'h0000_0150, rd);
      repeat (10) @(posedge clk_sys);
      apb(1'b0, rcr_pkg::OFS_READING, 32'h0);
      chk("free run", 32'h0000_2710, rd);
      mode(32'h0000_0154);
      meas(17'h0_4E21, 3'h0, 4'hA);
      mode(32'h0000_00A5);
      meas(17'h0_4E21, 3'h4, 4'h5);
      meas(17'h0_4E20, 3'h2, 4'h5);
      meas(17'h0_2710, 3'h2, 4'h5);
      meas(17'h0_270F, 3'h1, 4'h5);
      meas(17'h0_59D8, 3'h4, 4'h5);
      mode(32'h0000_00A6);
      meas(17'h0_2AF9, 3'h4, 4'h5);
      meas(17'h0_2AF8, 3'h2, 4'h5);
      meas(17'h0_2327, 3'h1, 4'h5);
      $display("test comparator done");
      mode(32'h0000_00B5);
      meas(17'h0_4EE7, 3'h4, 4'h5);
      meas(17'h0_4EE8, 3'h4, 4'h6);
      meas(17'h0_07D1, 3'h1, 4'h6);
      meas(17'h0_07D0, 3'h1, 4'h5);
      lat_f = lat;
      $display("test ranging done");
      for (int i = 0; i < 10; i++) begin
         apb(1'b1, ta_a[i], ta_d[i]);
         apb(1'b0, ta_a[i], 32'h0);
         chk("limits", ta_e[i], rd);
      end
      apb(1'b0, 8'h2C, 32'h0);
      chk("unmapped", 32'h1, 32'(err_v));
      apb(1'b1, rcr_pkg::OFS_CMD, 32'h0000_0012);
      apb(1'b1, rcr_pkg::OFS_BUSADDR, 32'h0000_0005);
      apb(1'b1, rcr_pkg::OFS_CMD, 32'h0000_0014);
      apb(1'b0, rcr_pkg::OFS_BUSADDR, 32'h0);
      chk("recall", 32'h0000_001E, rd);
      mode(32'h0000_008C);
      chk("lead check", 32'h1, 32'(lead_check_en));
      mode(32'h0000_0084);
      chk("lead check", 32'h0, 32'(lead_check_en));
      $display("test setup done");
      count_v <= 17'h0_1234;
      btn <= 1'b1;
      @(posedge clk_sys);
      btn <= 1'b0;
      repeat (20) @(posedge clk_sys);
      apb(1'b0, rcr_pkg::OFS_READING, 32'h0);
      chk("button trigger", 32'h0000_1234, rd);
      count_v <= 17'h0_0567;
      apb(1'b1, rcr_pkg::OFS_CMD, 32'h0000_0001);
      repeat (20) @(posedge clk_sys);
      apb(1'b0, rcr_pkg::OFS_READING, 32'h0);
      chk("command trigger", 32'h0000_0567, rd);
      apb(1'b1, rcr_pkg::OFS_DELAY, 32'h0000_0003);
      mode(32'h0000_00AD);
      meas(17'h0_4E21, 3'h4, 4'h5);
      lat = lat - lat_f - 3 * SIM_MS;
      chk("settle delay", 32'h1, 32'(lat >= 0 && lat <= 2));
      $display("test trigger done");
      stop_test();
   end
endmodule

// ### verilog/rcr_top.sv
// Purpose: reading comparator, range stepping, trigger sequencing and setup storage
// Assumes: inputs synchronous to clk_sys; core pulses meas_done once per meas_start
// Notes:   cmp bit 2 above high, bit 1 within, bit 0 below low
//
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/100ps
module rcr_top #(
   parameter int MS_CYC   = rcr_pkg::MS_CYC,
   parameter int DONE_CYC = rcr_pkg::DONE_CYC
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // measurement core
   output logic             meas_start,
   input  wire logic        meas_done,
   input  wire logic [16:0] meas_count,
   output logic      [3:0]  range_sel,
   output logic             lead_check_en,
   // handler side
   input  wire logic        trig_in_n,
   input  wire logic        button_trig,
   output logic             done_n,
   output logic             led_above_high,
   output logic             led_within,
   output logic             led_below_low,
   output logic             ttl_above_high,
   output logic             ttl_within,
   output logic             ttl_below_low,
   output logic             relay_above_high,
   output logic             relay_within,
   output logic             relay_below_low
);
   generate
      if (MS_CYC < 1 || MS_CYC > 131071 || DONE_CYC < 1 || DONE_CYC > 1048575) begin : g_chk
         $error("rcr_top: cycle count parameter out of range");
      end
   endgenerate

   // empty slots hold the reset setup so a recall never loads an illegal delay or address
   localparam rcr_pkg::rcr_setup_t RST_CFG = '{
      disp:     rcr_pkg::DISP_RES,
      trig:     rcr_pkg::TRIG_FAST_CONT,
      auto_rng: 1'b1,
      rng:      rcr_pkg::RST_RANGE,
      delay_ms: rcr_pkg::RST_DELAY,
      hi_lim:   rcr_pkg::RST_HI_LIM,
      lo_lim:   rcr_pkg::RST_LO_LIM,
      hi_pct:   rcr_pkg::RST_PCT,
      lo_pct:   rcr_pkg::RST_PCT,
      nominal:  rcr_pkg::RST_NOMINAL,
      bus_addr: rcr_pkg::RST_ADDR
   };

   rcr_pkg::rcr_state_t s_reg;
   rcr_pkg::rcr_state_t s_next;

   logic        wr;
   logic        rd_setup;
   logic        mapped;
   logic        ext_trig;
   logic        evt;
   logic        cmp_on;
   logic        delayed;
   logic        one_shot;
   logic [28:0] prod_hi;
   logic [28:0] prod_lo;
   logic [16:0] lim_hi;
   logic [16:0] lim_lo;
   logic [3:0]  slot;
   logic [3:0]  slot_idx;

   assign wr       = psel && penable && pwrite;
   assign rd_setup = psel && !penable && !pwrite;
   assign mapped   = (paddr <= rcr_pkg::OFS_READING) && (paddr[1:0] == 2'b00);
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !mapped;
   assign evt      = (s_reg.seq == rcr_pkg::SEQ_MEAS) && meas_done;
   assign cmp_on   = s_reg.cfg.disp != rcr_pkg::DISP_RES;
   assign delayed  = s_reg.cfg.trig[1];
   assign one_shot = s_reg.cfg.trig[0];
   assign ext_trig = (s_reg.trig_prev && !trig_in_n) || button_trig;
   assign slot     = pwdata[rcr_pkg::CMD_SLOT_LSB +: 4];
   assign slot_idx = slot - 4'h1;

   // percent limits are derived from the nominal count
   always_comb begin
      prod_hi = 29'(s_reg.cfg.nominal) * 29'(s_reg.cfg.hi_pct);
      prod_lo = 29'(s_reg.cfg.nominal) * 29'(s_reg.cfg.lo_pct);
      if (s_reg.cfg.disp == rcr_pkg::DISP_PCT) begin
         lim_hi = 17'(s_reg.cfg.nominal) + 17'(prod_hi / rcr_pkg::PCT_SCALE);
         lim_lo = 17'(s_reg.cfg.nominal) - 17'(prod_lo / rcr_pkg::PCT_SCALE);
      end else begin
         lim_hi = 17'(s_reg.cfg.hi_lim);
         lim_lo = 17'(s_reg.cfg.lo_lim);
      end
   end

   always_comb begin
      s_next       = s_reg;
      s_next.start = 1'b0;
      s_next.trig_prev = trig_in_n;

      // register writes
      if (wr) begin
         case (paddr)
            rcr_pkg::OFS_CTRL: begin
               if (pwdata[rcr_pkg::CTRL_DISP_LSB +: 2] != 2'b11) begin
                  s_next.cfg.disp = rcr_pkg::rcr_disp_t'(pwdata[rcr_pkg::CTRL_DISP_LSB +: 2]);
               end
               s_next.cfg.trig = rcr_pkg::rcr_trig_t'(pwdata[rcr_pkg::CTRL_TRIG_LSB +: 2]);
               s_next.cfg.auto_rng = pwdata[rcr_pkg::CTRL_AUTO_BIT];
               if (pwdata[rcr_pkg::CTRL_RNG_LSB +: 4] <= rcr_pkg::RANGE_TOP) begin
                  s_next.cfg.rng = pwdata[rcr_pkg::CTRL_RNG_LSB +: 4];
               end
            end
            rcr_pkg::OFS_DELAY: begin
               if (pwdata[7:0] >= rcr_pkg::DELAY_MIN && pwdata[7:0] <= rcr_pkg::DELAY_MAX
                   && pwdata[31:8] == 24'h00_0000) begin
                  s_next.cfg.delay_ms = pwdata[7:0];
               end
            end
            rcr_pkg::OFS_HI_LIM: begin
               if (pwdata <= 32'(rcr_pkg::MAX_COUNT)) begin
                  s_next.cfg.hi_lim = pwdata[14:0];
               end
            end
            rcr_pkg::OFS_LO_LIM: begin
               if (pwdata < 32'(s_reg.cfg.hi_lim)) begin
                  s_next.cfg.lo_lim = pwdata[14:0];
               end
            end
            rcr_pkg::OFS_HI_PCT: begin
               if (pwdata <= 32'(rcr_pkg::PCT_MAX)) begin
                  s_next.cfg.hi_pct = pwdata[13:0];
               end
            end
            rcr_pkg::OFS_LO_PCT: begin
               if (pwdata <= 32'(rcr_pkg::PCT_MAX)) begin
                  s_next.cfg.lo_pct = pwdata[13:0];
               end
            end
            rcr_pkg::OFS_NOMINAL: begin
               if (pwdata <= 32'(rcr_pkg::MAX_COUNT)) begin
                  s_next.cfg.nominal = pwdata[14:0];
               end
            end
            rcr_pkg::OFS_BUSADDR: begin
               if (pwdata >= 32'(rcr_pkg::ADDR_MIN) && pwdata <= 32'(rcr_pkg::ADDR_MAX)) begin
                  s_next.cfg.bus_addr = pwdata[4:0];
               end
            end
            rcr_pkg::OFS_CMD: begin
               if (slot >= 4'h1 && slot <= rcr_pkg::SLOT_COUNT) begin
                  if (pwdata[rcr_pkg::CMD_STORE_BIT]) begin
                     s_next.slots[slot_idx] = s_reg.cfg;
                  end else if (pwdata[rcr_pkg::CMD_RECALL_BIT]) begin
                     s_next.cfg = s_reg.slots[slot_idx];
                  end
               end
            end
            default: begin
            end
         endcase
      end

      // trigger sequencer
      case (s_reg.seq)
         rcr_pkg::SEQ_IDLE: begin
            if (!one_shot || s_reg.trig_pend) begin
               s_next.trig_pend = 1'b0;
               if (delayed) begin
                  s_next.seq     = rcr_pkg::SEQ_SETTLE;
                  s_next.ms_left = s_reg.cfg.delay_ms;
                  s_next.cyc_cnt = 17'(MS_CYC - 1);
               end else begin
                  s_next.seq   = rcr_pkg::SEQ_MEAS;
                  s_next.start = 1'b1;
               end
            end
         end
         rcr_pkg::SEQ_SETTLE: begin
            if (s_reg.cyc_cnt != 17'h0_0000) begin
               s_next.cyc_cnt = s_reg.cyc_cnt - 17'h0_0001;
            end else if (s_reg.ms_left > 8'h01) begin
               s_next.ms_left = s_reg.ms_left - 8'h01;
               s_next.cyc_cnt = 17'(MS_CYC - 1);
            end else begin
               s_next.seq   = rcr_pkg::SEQ_MEAS;
               s_next.start = 1'b1;
            end
         end
         rcr_pkg::SEQ_MEAS: begin
            if (meas_done) begin
               s_next.seq     = rcr_pkg::SEQ_IDLE;
               s_next.reading = meas_count;
               s_next.ovr     = meas_count > rcr_pkg::MAX_COUNT;
               if (s_reg.cfg.auto_rng) begin
                  if (meas_count >= rcr_pkg::UP_TH && s_reg.cfg.rng < rcr_pkg::RANGE_TOP) begin
                     s_next.cfg.rng = s_reg.cfg.rng + 4'h1;
                  end else if (meas_count <= rcr_pkg::DOWN_TH && s_reg.cfg.rng != 4'h0) begin
                     s_next.cfg.rng = s_reg.cfg.rng - 4'h1;
                  end
               end
               if (meas_count > lim_hi || meas_count > rcr_pkg::MAX_COUNT) begin
                  s_next.cmp = 3'b100;
               end else if (meas_count < lim_lo) begin
                  s_next.cmp = 3'b001;
               end else begin
                  s_next.cmp = 3'b010;
               end
               s_next.done_low = 1'b1;
               s_next.done_cnt = 20'(DONE_CYC - 1);
            end
         end
         default: begin
            s_next.seq = rcr_pkg::SEQ_IDLE;
         end
      endcase

      // a trigger arriving while busy is kept; it wins over a pending flag consumed now
      if (one_shot && (ext_trig || (wr && paddr == rcr_pkg::OFS_CMD
                                    && pwdata[rcr_pkg::CMD_TRIG_BIT]))) begin
         s_next.trig_pend = 1'b1;
      end

      if (s_next.cfg.disp == rcr_pkg::DISP_RES) begin
         s_next.cmp = 3'b000;
      end

      // reading-done low pulse
      if (s_reg.done_low && !evt) begin
         if (s_reg.done_cnt == 20'h0_0000) begin
            s_next.done_low = 1'b0;
         end else begin
            s_next.done_cnt = s_reg.done_cnt - 20'h0_0001;
         end
      end

      // read data captured in the setup phase
      if (rd_setup) begin
         case (paddr)
            rcr_pkg::OFS_CTRL: begin
               s_next.prdata = 32'({s_reg.cfg.rng, s_reg.cfg.auto_rng,
                                    s_reg.cfg.trig, s_reg.cfg.disp});
            end
            rcr_pkg::OFS_DELAY:   s_next.prdata = 32'(s_reg.cfg.delay_ms);
            rcr_pkg::OFS_HI_LIM:  s_next.prdata = 32'(s_reg.cfg.hi_lim);
            rcr_pkg::OFS_LO_LIM:  s_next.prdata = 32'(s_reg.cfg.lo_lim);
            rcr_pkg::OFS_HI_PCT:  s_next.prdata = 32'(s_reg.cfg.hi_pct);
            rcr_pkg::OFS_LO_PCT:  s_next.prdata = 32'(s_reg.cfg.lo_pct);
            rcr_pkg::OFS_NOMINAL: s_next.prdata = 32'(s_reg.cfg.nominal);
            rcr_pkg::OFS_BUSADDR: s_next.prdata = 32'(s_reg.cfg.bus_addr);
            rcr_pkg::OFS_STATUS: begin
               s_next.prdata = 32'h0000_0000;
               s_next.prdata[2:0] = s_reg.cmp;
               s_next.prdata[rcr_pkg::ST_OVR_BIT] = s_reg.ovr;
               s_next.prdata[rcr_pkg::ST_LEAD_BIT] = lead_check_en;
               s_next.prdata[rcr_pkg::ST_RNG_LSB +: 4] = s_reg.cfg.rng;
               s_next.prdata[rcr_pkg::ST_BUSY_BIT] = s_reg.seq != rcr_pkg::SEQ_IDLE;
            end
            rcr_pkg::OFS_READING: s_next.prdata = 32'(s_reg.reading);
            default:              s_next.prdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_reg           <= '0;
         s_reg.cfg       <= RST_CFG;
         s_reg.slots     <= {9{RST_CFG}};
         s_reg.seq       <= rcr_pkg::SEQ_IDLE;
         s_reg.trig_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign prdata           = s_reg.prdata;
   assign meas_start       = s_reg.start;
   assign range_sel        = s_reg.cfg.rng;
   assign lead_check_en    = delayed && (s_reg.cfg.rng < rcr_pkg::RANGE_LEAD);
   assign done_n           = !s_reg.done_low;
   assign led_above_high   = s_reg.cmp[2];
   assign led_within       = s_reg.cmp[1];
   assign led_below_low    = s_reg.cmp[0];
   assign ttl_above_high   = s_reg.cmp[2];
   assign ttl_within       = s_reg.cmp[1];
   assign ttl_below_low    = s_reg.cmp[0];
   assign relay_above_high = s_reg.cmp[2];
   assign relay_within     = s_reg.cmp[1];
   assign relay_below_low  = s_reg.cmp[0];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_above_high: assert property (evt && cmp_on && !wr && meas_count > lim_hi
                                  |=> led_above_high && relay_above_high)
      else $error("above-high state not set");
   a_within_lim: assert property (evt && cmp_on && !wr && meas_count >= lim_lo
                                  && meas_count <= lim_hi |=> led_within)
      else $error("within state not set");
   a_below_low: assert property (evt && cmp_on && !wr && meas_count < lim_lo
                                 |=> ttl_below_low)
      else $error("below-low state not set");
   a_res_quiet: assert property (!cmp_on |-> {led_above_high, led_within, led_below_low} == 3'b000)
      else $error("comparator active in resistance display");
   a_one_state: assert property (evt && cmp_on && !wr |=> $onehot({led_above_high, led_within,
                                 led_below_low}) [*2])
      else $error("comparator not one-hot after reading");
   a_step_down: assert property (evt && !wr && s_reg.cfg.auto_rng && s_reg.cfg.rng != 4'h0
                                 && meas_count <= rcr_pkg::DOWN_TH
                                 |=> range_sel == $past(range_sel) - 4'h1)
      else $error("auto range did not step down");
   a_step_up: assert property (evt && !wr && s_reg.cfg.auto_rng && s_reg.cfg.rng < rcr_pkg::RANGE_TOP
                               && meas_count >= rcr_pkg::UP_TH
                               |=> range_sel == $past(range_sel) + 4'h1)
      else $error("auto range did not step up");
   a_range_top: assert property (range_sel <= rcr_pkg::RANGE_TOP)
      else $error("range outside default set");
   a_settle_dly: assert property (s_reg.seq == rcr_pkg::SEQ_SETTLE |-> delayed)
      else $error("settling in a fast mode");
   a_fast_start: assert property (s_reg.seq == rcr_pkg::SEQ_IDLE && !delayed && !one_shot
                                  |=> meas_start)
      else $error("fast continuous start missing");
   a_delay_span: assert property (s_reg.cfg.delay_ms >= rcr_pkg::DELAY_MIN
                                  && s_reg.cfg.delay_ms <= rcr_pkg::DELAY_MAX)
      else $error("delay out of range");
   a_lo_guard: assert property (wr && paddr == rcr_pkg::OFS_LO_LIM
                                && pwdata >= 32'(s_reg.cfg.hi_lim)
                                |=> s_reg.cfg.lo_lim == $past(s_reg.cfg.lo_lim))
      else $error("lower limit accepted above upper");
   a_addr_span: assert property (s_reg.cfg.bus_addr >= rcr_pkg::ADDR_MIN
                                 && s_reg.cfg.bus_addr <= rcr_pkg::ADDR_MAX)
      else $error("bus address out of range");
   a_done_low: assert property (evt |=> !done_n [*8])
      else $error("reading-done pulse too short");
   a_one_shot: assert property (one_shot && s_reg.seq == rcr_pkg::SEQ_IDLE && !s_reg.trig_pend
                                |=> !meas_start)
      else $error("single-shot started without trigger");

   c_single_shot: cover property (one_shot && ext_trig ##[1:20] meas_start);
   c_step_up:     cover property (evt && s_reg.cfg.auto_rng && meas_count >= rcr_pkg::UP_TH);
   c_done_pulse:  cover property ($rose(done_n));
   c_recall:      cover property (wr && paddr == rcr_pkg::OFS_CMD && pwdata[rcr_pkg::CMD_RECALL_BIT]);
endmodule
